// ===== pues_pkg.sv
// Package for the power unit event selector: register map, field layout, event codes.
// Assumes a 32-bit APB slave with word-aligned registers.
package pues_pkg;

    localparam int PUES_NUM_CTR   = 4;
    localparam int PUES_CTR_WIDTH = 48;

    // Register byte offsets
    localparam logic [11:0] PUES_CTL0_OFF  = 12'h000;  // CTL n at 0x000 + 4n
    localparam logic [11:0] PUES_CTRLO_OFF = 12'h010;  // Counter n low word at 0x010 + 8n
    localparam logic [11:0] PUES_CTRHI_OFF = 12'h014;  // Counter n high word at 0x014 + 8n
    localparam logic [11:0] PUES_STAT_OFF  = 12'h030;  // Live event inputs

    // Control field positions
    localparam int PUES_EV_SEL_LSB = 0;
    localparam int PUES_UMASK_LSB  = 8;
    localparam int PUES_RST_BIT    = 17;
    localparam int PUES_EXT_BIT    = 21;
    localparam int PUES_EN_BIT     = 22;
    localparam logic [31:0] PUES_CTL_RST_VAL = 32'h0000_0000;
    localparam logic [31:0] PUES_CTL_WMASK   = 32'h0060_FFFF;

    // Nine-bit event codes: {extra select, code}
    localparam logic [8:0] PUES_EV_PERF_FLOOR = 9'h102;
    localparam logic [8:0] PUES_EV_FREQ_CHG   = 9'h100;
    localparam logic [8:0] PUES_EV_MEM_SHED   = 9'h02F;
    localparam logic [8:0] PUES_EV_OCCUPANCY  = 9'h080;
    localparam logic [8:0] PUES_EV_EXT_THROT  = 9'h00A;
    localparam logic [8:0] PUES_EV_INT_THROT  = 9'h009;
    localparam logic [8:0] PUES_EV_CSTATE_TR  = 9'h10B;
    localparam logic [8:0] PUES_EV_VOLT_CHG   = 9'h003;
    localparam logic [8:0] PUES_EV_VOLT_DOWN  = 9'h002;
    localparam logic [8:0] PUES_EV_VOLT_UP    = 9'h001;

    // Occupancy unit masks
    localparam logic [7:0] PUES_UM_ACTIVE = 8'h40;
    localparam logic [7:0] PUES_UM_LIGHT  = 8'h80;
    localparam logic [7:0] PUES_UM_DEEP   = 8'hC0;

    localparam int PUES_OCC_MAX = 8;

endpackage

// ===== pues_event_mux.sv
// Per-counter event selection: turns a control word into this cycle's increment.
// Assumes event inputs synchronous to pclk; purely combinational.
`timescale 1ns/1ps
module pues_event_mux
    import pues_pkg::*;
#(
    parameter int NUM_CORES = 8
) (
    input  wire logic [31:0] ctl,
    input  wire logic        perf_floor_limit_cycles,
    input  wire logic        frequency_change_cycles,
    input  wire logic        mem_phase_shed,
    input  wire logic        ext_throttle,
    input  wire logic        int_throttle,
    input  wire logic        cstate_transition,
    input  wire logic        voltage_up_cycles,
    input  wire logic        voltage_down_cycles,
    input  wire logic [3:0]  cores_active_state,
    input  wire logic [3:0]  cores_light_sleep,
    input  wire logic [3:0]  cores_deep_sleep,
    output logic      [3:0]  incr
);
    logic [8:0] code;
    logic [7:0] umask;

    always_comb begin
        code  = {ctl[PUES_EXT_BIT], ctl[PUES_EV_SEL_LSB +: 8]};
        umask = ctl[PUES_UMASK_LSB +: 8];
        incr  = 4'h0;
        // Cycle events add at most one
        unique case (code)
            PUES_EV_PERF_FLOOR: incr = {3'h0, perf_floor_limit_cycles};
            PUES_EV_FREQ_CHG:   incr = {3'h0, frequency_change_cycles};
            PUES_EV_MEM_SHED:   incr = {3'h0, mem_phase_shed};
            PUES_EV_EXT_THROT:  incr = {3'h0, ext_throttle};
            PUES_EV_INT_THROT:  incr = {3'h0, int_throttle};
            PUES_EV_CSTATE_TR:  incr = {3'h0, cstate_transition};
            PUES_EV_VOLT_CHG:   incr = {3'h0, voltage_up_cycles | voltage_down_cycles};
            PUES_EV_VOLT_DOWN:  incr = {3'h0, voltage_down_cycles};
            PUES_EV_VOLT_UP:    incr = {3'h0, voltage_up_cycles};
            PUES_EV_OCCUPANCY: begin
                unique case (umask)
                    PUES_UM_ACTIVE: incr = cores_active_state;
                    PUES_UM_LIGHT:  incr = cores_light_sleep;
                    PUES_UM_DEEP:   incr = cores_deep_sleep;
                    default:        incr = 4'h0;
                endcase
            end
            default: incr = 4'h0;
        endcase
    end
endmodule // pues_event_mux

// ===== pues_top.sv
// Power unit event selector: four 48-bit counters behind an APB slave.
// Assumes single clock pclk; event and occupancy inputs synchronous to it.
//
// Decided for this implementation: the placing of the registers and register access over APB.
`timescale 1ns/1ps
// Functional notes
// - Code 0x02 with extra bit counts cycles the perf floor holds frequency up.
// - Code 0x00 with extra bit counts frequency-change cycles, no thread filter.
// - Code 0x2F counts memory phase shedding cycles.
// - Code 0x80 adds the number of cores in the chosen state, up to 8.
// - Umask 0x40, 0x80, 0xC0 choose active, light sleep, deep sleep.
// - Code 0x0A counts external thermal-throttle cycles.
// - Code 0x09 counts internal thermal-throttle cycles.
// - Code 0x0B with extra bit counts core C-state transition cycles.
// - Code 0x03 counts cycles of voltage increase or decrease.
// - Code 0x02 without extra bit counts voltage-decrease cycles.
// - Code 0x01 counts voltage-increase cycles.
// - Cycle events add at most one; all events work on counters 0 to 3.
module pues_top
    import pues_pkg::*;
#(
    parameter int NUM_CORES = 8
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        perf_floor_limit_cycles,
    input  wire logic        frequency_change_cycles,
    input  wire logic        mem_phase_shed,
    input  wire logic        ext_throttle,
    input  wire logic        int_throttle,
    input  wire logic        cstate_transition,
    input  wire logic        voltage_up_cycles,
    input  wire logic        voltage_down_cycles,
    input  wire logic [3:0]  cores_active_state,
    input  wire logic [3:0]  cores_light_sleep,
    input  wire logic [3:0]  cores_deep_sleep
);
    // Occupancy inputs are four bits wide, so at most eight cores
    if (NUM_CORES < 1 || NUM_CORES > PUES_OCC_MAX) begin : g_bad_cores
        $error("NUM_CORES must be 1 to 8");
    end

    ////////////////////////////////////////////////////////////////////////
    // State
    typedef logic [PUES_CTR_WIDTH-1:0] pues_ctr_t;

    logic [31:0] ctl_reg     [PUES_NUM_CTR];
    logic [31:0] ctl_next    [PUES_NUM_CTR];
    pues_ctr_t   ctr_reg     [PUES_NUM_CTR];
    pues_ctr_t   ctr_next    [PUES_NUM_CTR];
    logic [3:0]  incr        [PUES_NUM_CTR];
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic        pready_reg;
    logic        pready_next;
    logic        pslverr_reg;
    logic        pslverr_next;

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;

    function automatic logic [31:0] pues_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) r[8*b +: 8] = new_v[8*b +: 8];
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Event selection, one mux per counter
    for (genvar g = 0; g < PUES_NUM_CTR; g++) begin : g_mux
        pues_event_mux #(.NUM_CORES(NUM_CORES)) u_mux (
            .ctl                     (ctl_reg[g]),
            .perf_floor_limit_cycles (perf_floor_limit_cycles),
            .frequency_change_cycles (frequency_change_cycles),
            .mem_phase_shed          (mem_phase_shed),
            .ext_throttle            (ext_throttle),
            .int_throttle            (int_throttle),
            .cstate_transition       (cstate_transition),
            .voltage_up_cycles       (voltage_up_cycles),
            .voltage_down_cycles     (voltage_down_cycles),
            .cores_active_state      (cores_active_state),
            .cores_light_sleep       (cores_light_sleep),
            .cores_deep_sleep        (cores_deep_sleep),
            .incr                    (incr[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // APB and counter next state
    logic        access;
    logic        wr;
    logic        hit;
    logic [31:0] hi_merge;
    always_comb begin
        access       = psel && penable && !pready_reg;
        wr           = access && pwrite;
        hit          = 1'b0;
        hi_merge     = 32'h0000_0000;
        prdata_next  = prdata_reg;
        pready_next  = access;
        pslverr_next = 1'b0;
        for (int i = 0; i < PUES_NUM_CTR; i++) begin
            ctl_next[i] = ctl_reg[i];
            ctr_next[i] = ctr_reg[i];
            // Counting runs while enabled; wraps at 48 bits
            if (ctl_reg[i][PUES_EN_BIT])
                ctr_next[i] = ctr_reg[i] + {{(PUES_CTR_WIDTH-4){1'b0}}, incr[i]};
        end
        if (access) begin
            prdata_next = 32'h0000_0000;
            if (paddr == PUES_STAT_OFF) begin
                hit = 1'b1;
                prdata_next = {20'h0_0000, voltage_down_cycles, voltage_up_cycles,
                               cstate_transition, int_throttle, ext_throttle,
                               mem_phase_shed, frequency_change_cycles,
                               perf_floor_limit_cycles, 4'h0};
                if (pwrite) pslverr_next = 1'b1;
            end
            for (int i = 0; i < PUES_NUM_CTR; i++) begin
                if (paddr == PUES_CTL0_OFF + 12'(4*i)) begin
                    hit = 1'b1;
                    prdata_next = ctl_reg[i] & ~(32'h1 << PUES_RST_BIT);
                    if (wr) begin
                        ctl_next[i] = pues_merge(ctl_reg[i], pwdata, pstrb)
                                      & PUES_CTL_WMASK;
                        // Counter clear is a one-shot, overrides counting
                        if (pstrb[2] && pwdata[PUES_RST_BIT])
                            ctr_next[i] = '0;
                    end
                end
                if (paddr == PUES_CTRLO_OFF + 12'(8*i)) begin
                    hit = 1'b1;
                    prdata_next = ctr_reg[i][31:0];
                    if (wr)
                        ctr_next[i][31:0] = pues_merge(ctr_reg[i][31:0], pwdata, pstrb);
                end
                if (paddr == PUES_CTRHI_OFF + 12'(8*i)) begin
                    hit = 1'b1;
                    prdata_next = {16'h0000, ctr_reg[i][47:32]};
                    if (wr) begin
                        hi_merge = pues_merge({16'h0000, ctr_reg[i][47:32]}, pwdata, pstrb);
                        ctr_next[i][47:32] = hi_merge[15:0];
                    end
                end
            end
            // Writes return zero data whatever the address
            if (pwrite) prdata_next = 32'h0000_0000;
            if (!hit) pslverr_next = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            for (int i = 0; i < PUES_NUM_CTR; i++) begin
                ctl_reg[i] <= PUES_CTL_RST_VAL;
                ctr_reg[i] <= '0;
            end
        end else begin
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
            for (int i = 0; i < PUES_NUM_CTR; i++) begin
                ctl_reg[i] <= ctl_next[i];
                ctr_reg[i] <= ctr_next[i];
            end
        end
    end
endmodule // pues_top

// ===== pues_monitor.sv
// Checker for the power unit event selector, APB side.
// Assumes binding to pues_top; one clock, asynchronous active-low reset.
`timescale 1ns/1ps
module pues_monitor
    import pues_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // First access cycle only; pready marks the second
    wire logic take = psel && penable && !pready;
    take_answer_a: assert property (take |=> pready) else $error("no answer after access");
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
    err_pair_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
    ready_cause_a: assert property (pready |-> $past(take)) else $error("pready without access");
    write_zero_a: assert property (take && pwrite |=> prdata == 32'h0)
        else $error("read data on a write");
    unmapped_err_a: assert property (take && paddr >= 12'h034 |=> pslverr)
        else $error("unmapped access accepted");
    stat_write_a: assert property (take && pwrite && paddr == 12'h030 |=> pslverr)
        else $error("status write accepted");
    ctl_bits_a: assert property (
        take && !pwrite && paddr < 12'h010 |=> (prdata & ~PUES_CTL_WMASK) == 32'h0)
        else $error("control bits outside fields");
    high_word_a: assert property (
        take && !pwrite && paddr >= 12'h010 && paddr < 12'h030 && paddr[2]
        |=> prdata[31:16] == 16'h0) else $error("counter wider than 48 bits");
endmodule // pues_monitor
////////////////////////////////////////////////////////////////
bind pues_top pues_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

// ===== pues_bench.sv
// Self-checking bench for the power unit event selector.
// Assumes pues_top with one wait state APB; the bench drives every port.
`timescale 1ns/1ps
module pues_bench;
    import pues_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, er;
    logic [7:0]  ev = 8'h00;
    logic [3:0]  c_act = 4'h0, c_lt = 4'h0, c_dp = 4'h0;
    int          miscompares = 0, comparisons = 0, cycles = 0;
    always #2 pclk = ~pclk;
    pues_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .perf_floor_limit_cycles(ev[0]),
        .frequency_change_cycles(ev[1]), .mem_phase_shed(ev[2]), .ext_throttle(ev[3]),
        .int_throttle(ev[4]), .cstate_transition(ev[5]), .voltage_up_cycles(ev[6]),
        .voltage_down_cycles(ev[7]), .cores_active_state(c_act),
        .cores_light_sleep(c_lt), .cores_deep_sleep(c_dp));
    ////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic wrap_up;
        $display("miscompares %0d comparisons %0d", miscompares, comparisons);
        if (miscompares == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Hangs on a missing pready end here
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            wrap_up();
        end
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Target inputs 5 cycles, every other input 3 cycles
    task automatic cycle_events;
        logic [8:0]  code [10] = '{PUES_EV_PERF_FLOOR, PUES_EV_FREQ_CHG, PUES_EV_MEM_SHED,
            PUES_EV_EXT_THROT, PUES_EV_INT_THROT, PUES_EV_CSTATE_TR, PUES_EV_VOLT_CHG,
            PUES_EV_VOLT_DOWN, PUES_EV_VOLT_UP, 9'h00B};
        logic [7:0]  mask [10] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'hC0, 8'h80,
            8'h40, 8'h00};
        logic [11:0] n;
        logic [31:0] want;
        for (int i = 0; i < 10; i++) begin
            n = 12'(i % 4);
            want = (mask[i] != 8'h00) ? 32'h5 : 32'h0;
            apb(1'b1, n << 2, 32'h0042_0000 | 32'(code[i][8]) << 21 | 32'(code[i][7:0]));
            @(posedge pclk);
            ev <= mask[i];
            repeat (5) @(posedge pclk);
            ev <= ~mask[i];
            repeat (3) @(posedge pclk);
            ev <= 8'h00;
            apb(1'b0, 12'h010 + (n << 3), 32'h0);
            check("count", rd, want);
            apb(1'b0, 12'h014 + (n << 3), 32'h0);
            check("high word", rd, 32'h0);
        end
    endtask
    // Three, five and eight cores for 4 cycles
    task automatic occupancy;
        logic [7:0]  um [4] = '{PUES_UM_ACTIVE, PUES_UM_LIGHT, PUES_UM_DEEP, 8'h20};
        logic [31:0] want [4] = '{32'hC, 32'h14, 32'h20, 32'h0};
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 12'(i << 2), 32'h0042_0080 | {16'h0, um[i], 8'h00});
            @(posedge pclk);
            c_act <= 4'h3;
            c_lt <= 4'h5;
            c_dp <= 4'h8;
            repeat (4) @(posedge pclk);
            c_act <= 4'h0;
            c_lt <= 4'h0;
            c_dp <= 4'h0;
            apb(1'b0, 12'h010 + 12'(i << 3), 32'h0);
            check("occupancy", rd, want[i]);
        end
    endtask
    task automatic refusals;
        apb(1'b0, 12'h034, 32'h0);
        check("unmapped err", {31'h0, er}, 32'h1);
        check("unmapped data", rd, 32'h0);
        apb(1'b1, PUES_STAT_OFF, 32'hFFFF_FFFF);
        check("status write err", {31'h0, er}, 32'h1);
        ev <= 8'hA5;
        apb(1'b0, PUES_STAT_OFF, 32'h0);
        check("status", rd, 32'h0000_0A50);
        ev <= 8'h00;
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, PUES_CTL0_OFF, 32'h0);
        check("control reset", rd, PUES_CTL_RST_VAL);
        cycle_events();
        occupancy();
        refusals();
        wrap_up();
    end
endmodule // pues_bench
